// file: ebcm_consts.vh
// Notes on behaviour
// - flag inactivity after 100 ms without cycles
// - reset asserted during inactivity reports reset
// - halt asserted during inactivity reports halt
// - bus request without dma cycles reports grant
// - pending cycle termination reports wait cause
// - otherwise report no memory cycles
// - halt sensed on target side of buffer
// - status byte: rw, size, mode, dma
// - bit 2 gives byte lane for bytes
// - function code in status bits six to four
// - map classifies emulation, target, guarded
// - 4k blocks wide bus, 256 narrow
// - guarded non-dma access breaks and latches address
// - select internal or target clock
// - compare 24 or 20 address bits
// - optional break on write to rom
// - isolated mode stops driving target halt and reset
`ifndef EBCM_CONSTS_VH
`define EBCM_CONSTS_VH
`define EBCM_CLK_MHZ 100
`define EBCM_IDLE_MS 100
`define EBCM_IDLE_CYC (`EBCM_IDLE_MS * 1000 * `EBCM_CLK_MHZ)
`define EBCM_A_CTRL 4'h0
`define EBCM_A_CAUSE 4'h1
`define EBCM_A_STAT 4'h2
`define EBCM_A_FAULT 4'h3
`define EBCM_A_MAP 4'h4
`define EBCM_A_IRQST 4'h5
`define EBCM_A_IRQMSK 4'h6
`define EBCM_A_MAPSEL 4'h7
`define EBCM_C_NARROW 0
`define EBCM_C_ISOLATE 1
`define EBCM_C_ROMBRK 2
`define EBCM_C_EXTCLK 3
`define EBCM_C_EXEC 4
`define EBCM_C_RUN 5
`define EBCM_CAUSE_NONE 3'h0
`define EBCM_CAUSE_RESET 3'h1
`define EBCM_CAUSE_HALT 3'h2
`define EBCM_CAUSE_GRANT 3'h3
`define EBCM_CAUSE_WAIT 3'h4
`define EBCM_CAUSE_NOMEM 3'h5
`define EBCM_MAP_EMUL 2'h0
`define EBCM_MAP_TARG 2'h1
`define EBCM_MAP_GUARD 2'h2
`define EBCM_MAP_ROM 2'h3
`endif

// file: ebcm_monitor.v
`include "ebcm_consts.vh"
module ebcm_monitor #(
    parameter IDLE_CYC = `EBCM_IDLE_CYC
)(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // emulated processor bus
    input wire [23:0] cpu_addr,
    input wire [2:0] cpu_fc,
    input wire cpu_as_n,
    input wire cpu_rw,
    input wire cpu_uds_n,
    input wire cpu_lds_n,
    input wire cpu_dma,
    input wire cycle_done,
    input wire host_reset,
    input wire cpu_reset_out,
    input wire cpu_halt_out,
    // target pins
    input wire transfer_ack_n,
    input wire valid_periph_addr_n,
    input wire bus_error_n,
    input wire bus_request_n,
    input wire tgt_halt_n_in,
    output wire tgt_halt_n_out,
    output wire tgt_halt_n_oe,
    input wire tgt_reset_n_in,
    output wire tgt_reset_n_out,
    output wire tgt_reset_n_oe,
    input wire tgt_present,
    // results
    output reg [7:0] cycle_status,
    output reg status_valid,
    output reg [1:0] region,
    output reg break_req,
    output wire clk_sel_ext,
    output wire irq
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg [2:0] s_ack, s_vpa, s_bus_error_n, s_br, s_halt, s_rst;
always @(posedge clk)
begin
    s_ack <= {s_ack[1:0], transfer_ack_n};
    s_vpa <= {s_vpa[1:0], valid_periph_addr_n};
    s_bus_error_n <= {s_bus_error_n[1:0], bus_error_n};
    s_br <= {s_br[1:0], bus_request_n};
    s_halt <= {s_halt[1:0], tgt_halt_n_in};
    s_rst <= {s_rst[1:0], tgt_reset_n_in};
end
// a pin counts as changed once stages two and three agree; until then
// the last settled level is kept, so a glitch never reaches the causes
function settle;
    input [2:0] s;
    input cur;
    begin
        settle = (s[1] == s[2]) ? s[2] : cur;
    end
endfunction
reg ack_n_reg, vpa_n_reg, bus_error_n_n_reg, br_n_reg, halt_n_reg, rst_n_reg;
always @(posedge clk)
begin
    if (!rst_n)
    begin
        ack_n_reg <= 1'b1;
        vpa_n_reg <= 1'b1;
        bus_error_n_n_reg <= 1'b1;
        br_n_reg <= 1'b1;
        halt_n_reg <= 1'b1;
        rst_n_reg <= 1'b1;
    end
    else
    begin
        ack_n_reg <= settle(s_ack, ack_n_reg);
        vpa_n_reg <= settle(s_vpa, vpa_n_reg);
        bus_error_n_n_reg <= settle(s_bus_error_n, bus_error_n_n_reg);
        br_n_reg <= settle(s_br, br_n_reg);
        halt_n_reg <= settle(s_halt, halt_n_reg);
        rst_n_reg <= settle(s_rst, rst_n_reg);
    end
end

// ----------------------------------------
// control registers
// ----------------------------------------
reg [5:0] ctrl_reg;
reg [11:0] map_sel_reg;
reg [3:0] irq_st_reg, irq_msk_reg;
reg [23:0] fault_addr_reg;
// one entry per block: 4k blocks over 24 bits and 256 byte blocks over
// 20 bits both need 4096 entries, so one table serves either bus width
reg [1:0] map_mem [0:4095];
wire narrow = ctrl_reg[`EBCM_C_NARROW];
wire isolate = ctrl_reg[`EBCM_C_ISOLATE];

// write decode shared by every location with a side effect
function wr_hit;
    input wr;
    input [3:0] a;
    input [3:0] target;
    begin
        wr_hit = wr && (a == target);
    end
endfunction
wire run_pulse = wr_hit(reg_wr, reg_addr, `EBCM_A_CTRL) && reg_wdata[`EBCM_C_RUN];
wire irq_clr_wr = wr_hit(reg_wr, reg_addr, `EBCM_A_IRQST);
wire map_wr = wr_hit(reg_wr, reg_addr, `EBCM_A_MAP);

// without a target only the internal clock is usable
assign clk_sel_ext = ctrl_reg[`EBCM_C_EXTCLK] & tgt_present;

// ----------------------------------------
// halt and reset buffering
// ----------------------------------------
// isolated: target neither sees host nor processor drive
assign tgt_halt_n_out = 1'b0;
assign tgt_reset_n_out = 1'b0;
assign tgt_halt_n_oe = ~isolate & cpu_halt_out;
assign tgt_reset_n_oe = ~isolate & (cpu_reset_out | host_reset);
// halt is seen on the target side only, so an isolated double fault is missed
wire halt_seen = ~halt_n_reg;
wire reset_seen = ~rst_n_reg | host_reset | (~isolate & cpu_reset_out);

// ----------------------------------------
// map decode
// ----------------------------------------
// 24 bits, 4k blocks wide; 20 bits, 256 byte blocks narrow
function [11:0] map_index;
    input [23:0] a;
    input n;
    begin
        map_index = n ? a[19:8] : a[23:12];
    end
endfunction
// bits above the compared width are ignored, so a narrow bus
// aliases its whole space across the upper address range
wire [1:0] map_type = map_mem[map_index(cpu_addr, narrow)];

// ----------------------------------------
// cycle status and breaks
// ----------------------------------------
reg as_d_reg;
reg guard_brk_reg, rom_brk_reg;
wire cyc_start = ~cpu_as_n & as_d_reg;
wire byte_cyc = cpu_uds_n ^ cpu_lds_n;
// dma cycles are the target's own traffic and never trip the guard
wire guard_hit = ~cpu_dma & (map_type == `EBCM_MAP_GUARD);
wire rom_hit = (map_type == `EBCM_MAP_ROM) & ~cpu_rw & ctrl_reg[`EBCM_C_ROMBRK];
always @(posedge clk)
begin
    if (!rst_n)
    begin
        as_d_reg <= 1'b1;
        cycle_status <= 8'h00;
        status_valid <= 1'b0;
        region <= `EBCM_MAP_EMUL;
        break_req <= 1'b0;
        guard_brk_reg <= 1'b0;
        rom_brk_reg <= 1'b0;
        fault_addr_reg <= 24'h00_0000;
    end
    else
    begin
        as_d_reg <= cpu_as_n;
        status_valid <= cyc_start;
        break_req <= cyc_start & (guard_hit | rom_hit);
        guard_brk_reg <= cyc_start & guard_hit;
        rom_brk_reg <= cyc_start & rom_hit;
        if (cyc_start)
        begin
            cycle_status[0] <= ~cpu_rw;
            cycle_status[1] <= byte_cyc;
            cycle_status[2] <= byte_cyc & ~cpu_uds_n;
            cycle_status[3] <= ctrl_reg[`EBCM_C_EXEC];
            cycle_status[6:4] <= cpu_fc;
            cycle_status[7] <= cpu_dma;
            // rom shows as emulation memory; only its write break differs
            region <= (map_type == `EBCM_MAP_ROM) ? `EBCM_MAP_EMUL : map_type;
            if (guard_hit)
            begin
                fault_addr_reg <= cpu_addr;
            end
        end
    end
end

// ----------------------------------------
// inactivity watch
// ----------------------------------------
localparam WATCH_OFF = 3'b001;
localparam WATCH_COUNT = 3'b010;
localparam WATCH_IDLE = 3'b100;
reg [2:0] watch_reg;
reg [31:0] idle_cnt_reg;
reg dma_seen_reg;
reg [2:0] cause_reg;
reg [2:0] cause_next;
wire idle_flag = (watch_reg == WATCH_IDLE);
wire grant_seen = ~br_n_reg & ~dma_seen_reg;
// a cycle waits while strobed and no termination line has answered
wire wait_seen = ~cpu_as_n & ack_n_reg & vpa_n_reg & bus_error_n_n_reg;

// fixed priority keeps exactly one cause even when lines overlap
always @*
begin
    cause_next = `EBCM_CAUSE_NOMEM;
    if (reset_seen)
    begin
        cause_next = `EBCM_CAUSE_RESET;
    end
    else if (halt_seen)
    begin
        cause_next = `EBCM_CAUSE_HALT;
    end
    else if (grant_seen)
    begin
        cause_next = `EBCM_CAUSE_GRANT;
    end
    else if (wait_seen)
    begin
        cause_next = `EBCM_CAUSE_WAIT;
    end
end

// dma activity only counts while the request is held
always @(posedge clk)
begin
    if (!rst_n)
    begin
        dma_seen_reg <= 1'b0;
    end
    else if (br_n_reg)
    begin
        dma_seen_reg <= 1'b0;
    end
    else if (cycle_done && cpu_dma)
    begin
        dma_seen_reg <= 1'b1;
    end
end

// counter saturates at the limit; the flag holds until a cycle or a run
always @(posedge clk)
begin
    if (!rst_n)
    begin
        watch_reg <= WATCH_OFF;
        idle_cnt_reg <= 32'h0000_0000;
        cause_reg <= `EBCM_CAUSE_NONE;
    end
    else if (run_pulse)
    begin
        // a new run restarts the interval and drops an old cause
        watch_reg <= WATCH_COUNT;
        idle_cnt_reg <= 32'h0000_0000;
        cause_reg <= `EBCM_CAUSE_NONE;
    end
    else
    begin
        case (watch_reg)
            WATCH_OFF:
            begin
                idle_cnt_reg <= 32'h0000_0000;
            end
            WATCH_COUNT:
            begin
                if (cycle_done)
                begin
                    idle_cnt_reg <= 32'h0000_0000;
                end
                else if (idle_cnt_reg < IDLE_CYC - 1)
                begin
                    idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
                end
                else
                begin
                    watch_reg <= WATCH_IDLE;
                    cause_reg <= cause_next;
                end
            end
            WATCH_IDLE:
            begin
                if (cycle_done)
                begin
                    watch_reg <= WATCH_COUNT;
                    idle_cnt_reg <= 32'h0000_0000;
                    cause_reg <= `EBCM_CAUSE_NONE;
                end
                else
                begin
                    // cause follows the lines while the stall lasts
                    cause_reg <= cause_next;
                end
            end
            default:
            begin
                watch_reg <= WATCH_OFF;
            end
        endcase
    end
end

// ----------------------------------------
// interrupts and register access
// ----------------------------------------
// bits: 0 idle, 1 guarded, 2 rom write, 3 spare
reg idle_d_reg;
reg [31:0] rdata_next;
wire [3:0] irq_ev = {1'b0, rom_brk_reg, guard_brk_reg, idle_flag & ~idle_d_reg};
wire [3:0] irq_clr = irq_clr_wr ? reg_wdata[3:0] : 4'h0;
assign irq = |(irq_st_reg & irq_msk_reg);

// decoded here and registered below, so read data stand one clean cycle
always @*
begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
        `EBCM_A_CTRL: rdata_next = {26'h000_0000, ctrl_reg};
        `EBCM_A_CAUSE: rdata_next = {28'h000_0000, cause_reg, idle_flag};
        `EBCM_A_STAT: rdata_next = {24'h00_0000, cycle_status};
        `EBCM_A_FAULT: rdata_next = {8'h00, fault_addr_reg};
        `EBCM_A_MAP: rdata_next = {30'h0000_0000, map_mem[map_sel_reg]};
        `EBCM_A_IRQST: rdata_next = {28'h000_0000, irq_st_reg};
        `EBCM_A_IRQMSK: rdata_next = {28'h000_0000, irq_msk_reg};
        `EBCM_A_MAPSEL: rdata_next = {20'h0_0000, map_sel_reg};
        default: rdata_next = 32'h0000_0000;
    endcase
end

always @(posedge clk)
begin
    if (!rst_n)
    begin
        ctrl_reg <= 6'h00;
        map_sel_reg <= 12'h000;
        irq_st_reg <= 4'h0;
        irq_msk_reg <= 4'h0;
        idle_d_reg <= 1'b0;
        reg_rdata <= 32'h0000_0000;
    end
    else
    begin
        idle_d_reg <= idle_flag;
        // set wins over write-one clear
        irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
        if (reg_wr)
        begin
            case (reg_addr)
                `EBCM_A_CTRL: ctrl_reg <= {1'b0, reg_wdata[4:0]};
                `EBCM_A_MAPSEL: map_sel_reg <= reg_wdata[11:0];
                `EBCM_A_IRQMSK: irq_msk_reg <= reg_wdata[3:0];
                default: ;
            endcase
        end
        // zero outside the answer cycle
        reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
end

// map table has no reset; software loads it before a run
always @(posedge clk)
begin
    if (map_wr)
    begin
        map_mem[map_sel_reg] <= reg_wdata[1:0];
    end
end
endmodule

// file: ebcm_monitor_bench.sv
module ebcm_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n, reg_wr, reg_rd, cpu_as_n, cpu_rw, cpu_uds_n, cpu_lds_n, cpu_dma, cycle_done;
    logic host_reset, cpu_halt_out, bus_request_n, tgt_present, stall, halt_drv;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [23:0] cpu_addr;
    logic [2:0] cpu_fc;
    logic [1:0] lane;
    wire [31:0] reg_rdata;
    wire [7:0] cycle_status;
    wire [1:0] region;
    wire transfer_ack_n, valid_periph_addr_n, bus_error_n, tgt_halt_n_oe, tgt_reset_n_oe;
    wire status_valid, break_req, clk_sel_ext, irq;
    // open-drain halt: low when either side pulls
    wire tgt_halt_n_in = !(halt_drv | tgt_halt_n_oe);
    wire tgt_reset_n_in = !tgt_reset_n_oe;
    int n_errors = 0;
    int cmp_count = 0;
    int i;
    always #5 clk = !clk;
    ebcm_monitor #(.IDLE_CYC(20)) i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cpu_addr, .cpu_fc, .cpu_as_n, .cpu_rw, .cpu_uds_n, .cpu_lds_n, .cpu_dma,
        .cycle_done, .host_reset, .cpu_reset_out(1'h0), .cpu_halt_out, .transfer_ack_n,
        .valid_periph_addr_n, .bus_error_n, .bus_request_n, .tgt_halt_n_in, .tgt_halt_n_out(),
        .tgt_halt_n_oe, .tgt_reset_n_in, .tgt_reset_n_out(), .tgt_reset_n_oe, .tgt_present,
        .cycle_status, .status_valid, .region, .break_req, .clk_sel_ext, .irq);
    ebcm_tgt_model u_tgt (.clk, .cpu_as_n, .ack_dly(i[3:0]), .stall, .transfer_ack_n,
        .valid_periph_addr_n, .bus_error_n);
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input [3:0] a, input [23:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= {8'h00, d};
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input [3:0] a, input [23:0] e, input [23:0] m = 24'hFF_FFFF);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(posedge clk);
        chk(reg_rdata & {8'hFF, m}, {8'h00, e});
    endtask
    task automatic cyc(input [23:0] a, input [2:0] fc, input rw, input [1:0] ds, input dma);
        int n;
        @(posedge clk);
        cpu_addr <= a;
        cpu_fc <= fc;
        cpu_rw <= rw;
        {cpu_uds_n, cpu_lds_n} <= ds;
        cpu_dma <= dma;
        cpu_as_n <= 1'h0;
        for (n = 0; n < 30 && transfer_ack_n !== 1'h0; n++)
            @(posedge clk);
        cpu_as_n <= 1'h1;
        cycle_done <= 1'h1;
        @(posedge clk);
        cycle_done <= 1'h0;
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        rst_n = 1'h0;
        {reg_wr, reg_rd, cpu_rw, cpu_dma, cycle_done, host_reset, cpu_halt_out} = '0;
        {cpu_as_n, cpu_uds_n, cpu_lds_n, bus_request_n, tgt_present} = '1;
        {stall, halt_drv, reg_addr, reg_wdata, cpu_addr, cpu_fc, i} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rd(4'h1, 24'h00_0000);
        rd(4'hF, 24'h00_0000);
        for (i = 0; i < 4; i++)
        begin
            wr(4'h7, {16'h0000, i[3:0], 4'h0});
            wr(4'h4, i[23:0]);
        end
        for (i = 0; i < 3; i++)
        begin
            cyc({i[7:0], 16'h0000}, 3'h5, 1'h1, 2'h0, 1'h0);
            chk(region, i[1:0]);
        end
        rd(4'h5, 24'h00_0002);
        rd(4'h3, 24'h02_0000);
        chk(irq, 1'h0);
        wr(4'h6, 24'h00_0002);
        @(posedge clk);
        chk(irq, 1'h1);
        wr(4'h5, 24'h00_0002);
        @(posedge clk);
        chk(irq, 1'h0);
        // narrow bus: 256 byte block 3 guarded, execute mode set
        wr(4'h7, 24'h00_0003);
        wr(4'h4, 24'h00_0002);
        wr(4'h0, 24'h00_0011);
        cyc(24'h00_0300, 3'h6, 1'h1, 2'h0, 1'h0);
        chk(region, 2'h2);
        rd(4'h2, 24'h00_0068);
        wr(4'h5, 24'h00_0002);
        wr(4'h0, 24'h00_0000);
        // every function code, lane and direction
        for (i = 0; i < 8; i++)
        begin
            lane = i % 3 == 1 ? 2'h3 : i % 3 == 2 ? 2'h1 : 2'h0;
            cyc(24'h00_0000, i[2:0], i[0], 2'(i % 3), i[2]);
            rd(4'h2, {16'h0000, i[2], i[2:0], 1'h0, lane, !i[0]});
        end
        wr(4'h0, 24'h00_0004);
        cyc(24'h03_0000, 3'h5, 1'h1, 2'h0, 1'h0);
        rd(4'h5, 24'h00_0000);
        cyc(24'h03_0000, 3'h5, 1'h0, 2'h0, 1'h0);
        rd(4'h5, 24'h00_0004);
        wr(4'h5, 24'h00_0004);
        wr(4'h0, 24'h00_0008);
        @(posedge clk);
        chk(clk_sel_ext, 1'h1);
        tgt_present <= 1'h0;
        @(posedge clk);
        chk(clk_sel_ext, 1'h0);
        // idle causes; last pass halts behind the isolating buffer
        for (i = 0; i < 6; i++)
        begin
            @(posedge clk);
            host_reset <= i == 0;
            halt_drv <= i == 1;
            bus_request_n <= i != 2;
            stall <= i == 3;
            cpu_as_n <= i != 3;
            cpu_halt_out <= i == 1 || i == 5;
            wr(4'h0, i == 5 ? 24'h00_0022 : 24'h00_0020);
            repeat (40) @(posedge clk);
            rd(4'h1, {20'h0_0000, i == 5 ? 3'h5 : 3'(i + 1), 1'h1});
            chk(tgt_halt_n_oe, i == 1);
            {host_reset, halt_drv, stall, cpu_halt_out} <= '0;
            bus_request_n <= 1'h1;
            cpu_as_n <= 1'h1;
            cycle_done <= 1'h1;
            @(posedge clk);
            cycle_done <= 1'h0;
            rd(4'h1, 24'h00_0000, 24'h00_0001);
        end
        complete_run;
    end
    initial
    begin
        #50us;
        n_errors++;
        complete_run;
    end
endmodule

// file: ebcm_props.sv
module ebcm_props (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // processor bus
    input wire cpu_as_n,
    input wire cpu_rw,
    input wire [2:0] cpu_fc,
    input wire cpu_uds_n,
    input wire cpu_lds_n,
    input wire cpu_dma,
    input wire tgt_present,
    // results
    input wire [7:0] cycle_status,
    input wire status_valid,
    input wire [1:0] region,
    input wire break_req,
    input wire clk_sel_ext
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence cyc_start;
        $fell(cpu_as_n);
    endsequence
    stat_pulse_a: assert property (cyc_start |=> status_valid ##1 !status_valid)
        else $error("status pulse wrong");
    stat_rw_a: assert property (cyc_start |=> cycle_status[0] == !$past(cpu_rw))
        else $error("direction bit wrong");
    stat_dma_a: assert property (cyc_start |=> cycle_status[7] == $past(cpu_dma))
        else $error("dma bit wrong");
    stat_fc_a: assert property (cyc_start |=> cycle_status[6:4] == $past(cpu_fc))
        else $error("function code wrong");
    stat_lane_a: assert property (cyc_start |=> cycle_status[2:1] ==
        ($past(cpu_lds_n) ? 2'h3 : {1'h0, $past(cpu_uds_n)})) else $error("lane bits wrong");
    brk_src_a: assert property (break_req |-> status_valid)
        else $error("break without cycle");
    guard_brk_a: assert property (
        status_valid && region == 2'h2 && !cycle_status[7] |-> break_req)
        else $error("guarded access missed");
    clk_sel_a: assert property (clk_sel_ext |-> tgt_present)
        else $error("target clock without target");
endmodule
bind ebcm_monitor ebcm_props u_props (.clk, .rst_n, .cpu_as_n, .cpu_rw, .cpu_fc, .cpu_uds_n,
    .cpu_lds_n, .cpu_dma, .tgt_present, .cycle_status, .status_valid, .region, .break_req,
    .clk_sel_ext);

// file: ebcm_tgt_model.sv
module ebcm_tgt_model (
    // bus side
    input wire clk,
    input wire cpu_as_n,
    // scenario control
    input wire [3:0] ack_dly,
    input wire stall,
    // target pins
    output logic transfer_ack_n = 1'h1,
    output wire valid_periph_addr_n,
    output wire bus_error_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg = 4'h0;
    // pulled-up terminations, never used here
    assign valid_periph_addr_n = 1'h1;
    assign bus_error_n = 1'h1;
    // ----------------------------------------
    // acknowledge after a programmable delay
    // ----------------------------------------
    always @(posedge clk)
    begin
        cnt_reg <= cpu_as_n ? 4'h0 : cnt_reg + 4'h1;
        transfer_ack_n <= cpu_as_n || stall || cnt_reg < ack_dly;
    end
endmodule
